// File: machine_status_map.svh
// constants for the machine status and identity block: csr numbers,
// status word field positions, encodings and reset values.
// assumes inclusion by bare name from any file of the block.
`ifndef MACHINE_STATUS_MAP_SVH
`define MACHINE_STATUS_MAP_SVH

// csr numbers on the 12-bit csr address
`define CSR_IMPL_VERSION    12'hF13
`define CSR_HART_IDENTITY   12'hF14
`define CSR_STATUS_WORD     12'h300

// privilege encodings
`define PRIV_USER           2'h0
`define PRIV_SUPER          2'h1
`define PRIV_HYP            2'h2
`define PRIV_MACHINE        2'h3

// status word field positions
`define ST_IE_LO            0
`define ST_PIE_LO           4
`define ST_SPP              8
`define ST_HPP_LO           9
`define ST_MPP_LO           11
`define ST_FS_LO            13
`define ST_XS_LO            15
`define ST_MODIFY_PRIVILEGE             17
`define ST_PUM              18
`define ST_MXR              19
`define ST_VM_LO            24

// translation scheme codes
`define XLAT_BARE           5'h00
`define XLAT_BASE_BOUND     5'h01
`define XLAT_SPLIT_BOUND    5'h02
`define XLAT_PAGED_32       5'h08
`define XLAT_PAGED_39       5'h09
`define XLAT_PAGED_48       5'h0A

// extension status encoding
`define EXT_DIRTY           2'h3

// reset values
`define RESET_MODE          2'h3
`define RESET_XLAT          5'h00

`endif

// File: machine_status_pkg.sv
// types shared by the machine status block, its port-level checker and its self-checking bench.
// assumes the constants header is compiled alongside.
package machine_status_pkg;

  typedef logic [1:0] priv_t;

  typedef enum logic [1:0] {
    CSR_IDLE,
    CSR_WRITE,
    CSR_SET,
    CSR_CLEAR
  } csr_op_t;

  typedef struct packed {
    csr_op_t     op;
    logic [11:0] addr;
  } csr_req_t;

  typedef struct packed {
    priv_t       mode;
    logic [3:0]  ie;
    logic [3:0]  pie;
    logic        super_prev_mode;
    logic [1:0]  hyp_prev_mode;
    logic [1:0]  machine_prev_mode;
    logic [1:0]  fs;
    logic        modify_privilege;
    logic        protect_user_pages;
    logic        exec_readable;
    logic [4:0]  vm;
    logic [63:0] rdata;
    logic        rvalid;
    logic        rfault;
    logic [3:0]  irqTake;
    priv_t       dataMode;
    logic        dirty;
  } status_state_t;

endpackage

// File: xlat_scheme_legalize.sv
// legaliser for the translation scheme field: keeps the held code when
// the requested one is unsupported or reserved.
// assumes a combinational caller on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "machine_status_map.svh"

module xlat_scheme_legalize #(
  parameter int XLEN    = 64,
  parameter bit HAS_U   = 1'b1,
  parameter bit HAS_S   = 1'b1
) (
  input  wire logic [4:0] requested,
  input  wire logic [4:0] held,
  output logic      [4:0] legal
);

  logic supported;

  always_comb begin
    supported = 1'b0;
    unique case (requested)
      `XLAT_BARE:        supported = 1'b1;
      `XLAT_BASE_BOUND,
      `XLAT_SPLIT_BOUND: supported = HAS_U;
      `XLAT_PAGED_32:    supported = HAS_U && HAS_S && XLEN == 32;
      `XLAT_PAGED_39,
      `XLAT_PAGED_48:    supported = HAS_U && HAS_S && XLEN == 64;
      default:           supported = 1'b0;
    endcase
    // reserved codes never stick, so a read-back exposes the refusal
    legal = supported ? requested : held;
  end

endmodule

`default_nettype wire

// File: machine_status_trap_stack.sv
// machine status word, implementation version and hart identity,
// with the privilege/interrupt-enable stack and interrupt gating.
// assumes a core that issues csr ops, trap entries and returns as pulses.
//
// Functional notes
// - implementation version always readable; zero allowed when no version is given
// - version value left-justified, subfields on nibble boundaries
// - hart identity is read-only; some hart in the system has identity zero
// - status word is a full-width read/write register of the thread state
// - per-mode interrupt enables sit in the lowest status bits
// - own-mode interrupts need enable; lower always masked, higher always enabled
// - trap y to x: prev enable gets y enable, enable cleared, prev mode y
// - machine and hyp prev modes two bits, super one bit, user none
// - return: restore enable, switch mode, prev enable 1, prev mode lowest
// - prev-mode fields hold only supported modes; machine-only fixes it at 11
// - without user interrupts user enables read zero; other modes have all fields
// - scheme 0 bare, 1 single base-bound, 2 split base-bound
// - schemes 8, 9, 10 paged 32/39/48 bit; 11, 12 reserved
// - scheme field keeps a legal value on unsupported writes
// - bare scheme selected at reset, addresses are machine physical
// - base-bound schemes only with user and machine modes; the code accepts them whenever user mode exists, supervisor present or not
// - paged schemes only with machine, supervisor and user modes
// - dirty summary set when float or extension state is dirty
// - modify-privilege makes loads and stores use machine prev mode
`timescale 1ns/1ps
`default_nettype none
`include "machine_status_map.svh"

module machine_status_trap_stack #(
  parameter int          XLEN       = 64,
  parameter bit          HAS_U      = 1'b1,
  parameter bit          HAS_S      = 1'b1,
  parameter bit          HAS_H      = 1'b0,
  parameter bit          HAS_N      = 1'b0,
  parameter bit          HAS_FLOAT  = 1'b1,
  // arbitrary value, left-justified as a version string would be
  parameter logic [63:0] IMPL_ID    = 64'h1200_0000_0000_0000,
  parameter logic [63:0] HART_ID    = 64'h0000_0000_0000_0000
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire machine_status_pkg::csr_req_t  csrReq,
  input  wire logic [XLEN-1:0]               csrWdata,
  input  wire logic                          trapEnter,
  input  wire machine_status_pkg::priv_t     trapTarget,
  input  wire logic                          trapReturn,
  input  wire machine_status_pkg::priv_t     returnFrom,
  input  wire logic [3:0]                    irqPending,
  input  wire logic [1:0]                    extState,
  output logic      [XLEN-1:0]               csrRdata,
  output logic                               csrValid,
  output logic                               csrFault,
  output machine_status_pkg::priv_t          curMode,
  output machine_status_pkg::priv_t          dataMode,
  output logic      [3:0]                    irqTake,
  output logic      [4:0]                    xlatScheme,
  output logic                               dirtySummary,
  output logic                               modifyPrivilege,
  output logic                               protectUserPages,
  output logic                               execReadable
);

  machine_status_pkg::status_state_t st;
  machine_status_pkg::status_state_t next_st;

  logic [4:0]  legalVm;
  logic [4:0]  reqVm;
  logic [63:0] curWord;

  // which privilege modes exist
  function automatic logic modeOk(input machine_status_pkg::priv_t m);
    unique case (m)
      `PRIV_USER:    modeOk = HAS_U;
      `PRIV_SUPER:   modeOk = HAS_S;
      `PRIV_HYP:     modeOk = HAS_H;
      default:       modeOk = 1'b1;
    endcase
  endfunction

  // lowest supported mode, put at the stack bottom on return
  function automatic machine_status_pkg::priv_t lowestMode();
    lowestMode = HAS_U ? `PRIV_USER : `PRIV_MACHINE;
  endfunction

  // a prev-mode field stores only supported modes not above its owner
  function automatic machine_status_pkg::priv_t legalPrev(
    input machine_status_pkg::priv_t owner,
    input machine_status_pkg::priv_t v
  );
    legalPrev = (modeOk(v) && v <= owner) ? v : lowestMode();
  endfunction

  // enable bits that exist; the rest read zero and drop writes
  function automatic logic [3:0] enableMask();
    enableMask = {1'b1, HAS_H, HAS_S, HAS_U && HAS_N};
  endfunction

  // float state field exists with a float unit or supervisor mode
  function automatic logic fsExists();
    fsExists = HAS_FLOAT || HAS_S;
  endfunction

  // assemble the status word from state
  function automatic logic [63:0] statusWord(
    input machine_status_pkg::status_state_t s,
    input logic [1:0] xs
  );
    logic [63:0] w;
    w = 64'h0000_0000_0000_0000;
    w[`ST_IE_LO +: 4]  = s.ie;
    w[`ST_PIE_LO +: 4] = s.pie;
    w[`ST_SPP]         = s.super_prev_mode;
    w[`ST_HPP_LO +: 2] = s.hyp_prev_mode;
    w[`ST_MPP_LO +: 2] = s.machine_prev_mode;
    w[`ST_FS_LO +: 2]  = s.fs;
    w[`ST_XS_LO +: 2]  = xs;
    w[`ST_MODIFY_PRIVILEGE]        = s.modify_privilege;
    w[`ST_PUM]         = s.protect_user_pages;
    w[`ST_MXR]         = s.exec_readable;
    w[`ST_VM_LO +: 5]  = s.vm;
    w[XLEN-1]          = (s.fs == `EXT_DIRTY) || (xs == `EXT_DIRTY);
    statusWord = w;
  endfunction

  // interrupt gating for a given running mode
  function automatic logic [3:0] gateIrq(
    input machine_status_pkg::priv_t m,
    input logic [3:0] ie,
    input logic [3:0] pend
  );
    logic [3:0] g;
    g = 4'h0;
    for (int t = 0; t < 4; t++) begin
      if (t > m) begin
        g[t] = pend[t];
      end else if (t == m) begin
        g[t] = pend[t] && ie[t];
      end else begin
        g[t] = 1'b0;
      end
    end
    gateIrq = g;
  endfunction

  assign curWord = statusWord(st, extState);

  xlat_scheme_legalize #(
    .XLEN      (XLEN),
    .HAS_U     (HAS_U),
    .HAS_S     (HAS_S)
  ) u_xlat (
    .requested (reqVm),
    .held      (st.vm),
    .legal     (legalVm)
  );

  always_comb begin
    logic [63:0]               wide;
    logic [63:0]               wv;
    logic                      isStatus;
    logic                      isRo;
    logic [3:0]                enMask;
    machine_status_pkg::priv_t x;
    machine_status_pkg::priv_t y;
    wide     = 64'h0000_0000_0000_0000;
    wv       = curWord;
    isStatus = 1'b0;
    isRo     = 1'b0;
    enMask   = enableMask();
    x        = `PRIV_MACHINE;
    y        = `PRIV_MACHINE;
    next_st  = st;
    reqVm    = st.vm;

    wide[XLEN-1:0] = csrWdata;
    next_st.rvalid = 1'b0;
    next_st.rfault = 1'b0;

    // csr access: every op reads, write/set/clear then modify
    if (csrReq.op != machine_status_pkg::CSR_IDLE) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 64'h0000_0000_0000_0000;
      unique case (csrReq.addr)
        `CSR_IMPL_VERSION: begin
          next_st.rdata = IMPL_ID;
          isRo          = 1'b1;
        end
        `CSR_HART_IDENTITY: begin
          next_st.rdata = HART_ID;
          isRo          = 1'b1;
        end
        `CSR_STATUS_WORD: begin
          next_st.rdata = curWord;
          isStatus      = 1'b1;
        end
        default: begin
          next_st.rfault = 1'b1;
        end
      endcase
      if (XLEN < 64) begin
        next_st.rdata = next_st.rdata & ((64'h0000_0000_0000_0001 << XLEN) - 64'h0000_0000_0000_0001);
      end
      // identity registers fault on a write op only; set and clear pass without a fault, value unchanged
      if (isRo && csrReq.op == machine_status_pkg::CSR_WRITE) begin
        next_st.rfault = 1'b1;
      end
    end

    unique case (csrReq.op)
      machine_status_pkg::CSR_WRITE: wv = wide;
      machine_status_pkg::CSR_SET:   wv = curWord | wide;
      machine_status_pkg::CSR_CLEAR: wv = curWord & ~wide;
      default:                       wv = curWord;
    endcase

    // trap entry wins over a return, which wins over a csr update
    if (trapEnter) begin
      x = modeOk(trapTarget) ? trapTarget : `PRIV_MACHINE;
      y = st.mode;
      next_st.pie[x] = st.ie[y] & enMask[y];
      next_st.ie[x]  = 1'b0;
      unique case (x)
        `PRIV_MACHINE: next_st.machine_prev_mode = legalPrev(`PRIV_MACHINE, y);
        `PRIV_HYP:     next_st.hyp_prev_mode = legalPrev(`PRIV_HYP, y);
        `PRIV_SUPER:   next_st.super_prev_mode = y[0];
        default:       ;
      endcase
      next_st.mode = x;
    end else if (trapReturn) begin
      x = returnFrom;
      unique case (x)
        `PRIV_MACHINE: y = st.machine_prev_mode;
        `PRIV_HYP:     y = st.hyp_prev_mode;
        `PRIV_SUPER:   y = {1'b0, st.super_prev_mode};
        default:       y = `PRIV_USER;
      endcase
      next_st.ie[y]  = st.pie[x];
      next_st.pie[x] = 1'b1;
      next_st.mode   = y;
      unique case (x)
        `PRIV_MACHINE: next_st.machine_prev_mode = lowestMode();
        `PRIV_HYP:     next_st.hyp_prev_mode = lowestMode();
        `PRIV_SUPER:   next_st.super_prev_mode = 1'b0;
        default:       ;
      endcase
    end else if (isStatus && csrReq.op != machine_status_pkg::CSR_IDLE) begin
      next_st.ie   = wv[`ST_IE_LO +: 4];
      next_st.pie  = wv[`ST_PIE_LO +: 4];
      next_st.super_prev_mode  = wv[`ST_SPP];
      next_st.hyp_prev_mode  = legalPrev(`PRIV_HYP, wv[`ST_HPP_LO +: 2]);
      next_st.machine_prev_mode  = legalPrev(`PRIV_MACHINE, wv[`ST_MPP_LO +: 2]);
      next_st.fs   = wv[`ST_FS_LO +: 2];
      next_st.modify_privilege = wv[`ST_MODIFY_PRIVILEGE];
      next_st.protect_user_pages  = wv[`ST_PUM];
      next_st.exec_readable  = wv[`ST_MXR];
      reqVm        = wv[`ST_VM_LO +: 5];
      next_st.vm   = legalVm;
    end

    // unimplemented fields stay hardwired whatever the source
    next_st.ie  = next_st.ie & enableMask();
    next_st.pie = next_st.pie & enableMask();
    if (!HAS_S) begin
      next_st.super_prev_mode = 1'b0;
    end
    if (!HAS_H) begin
      next_st.hyp_prev_mode = 2'h0;
    end
    if (!HAS_U) begin
      next_st.machine_prev_mode = `PRIV_MACHINE;
    end
    if (!fsExists()) begin
      next_st.fs = 2'h0;
    end

    // registered views for the core, one cycle behind the state
    next_st.irqTake  = gateIrq(st.mode, st.ie, irqPending);
    next_st.dataMode = st.modify_privilege ? st.machine_prev_mode : st.mode;
    next_st.dirty    = (st.fs == `EXT_DIRTY) || (extState == `EXT_DIRTY);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st          <= '0;
      st.mode     <= `RESET_MODE;
      st.machine_prev_mode      <= HAS_U ? `PRIV_USER : `PRIV_MACHINE;
      st.vm       <= `RESET_XLAT;
      st.dataMode <= `RESET_MODE;
    end else begin
      st <= next_st;
    end
  end

  assign csrRdata         = st.rdata[XLEN-1:0];
  assign csrValid         = st.rvalid;
  assign csrFault         = st.rfault;
  assign curMode          = st.mode;
  assign dataMode         = st.dataMode;
  assign irqTake          = st.irqTake;
  assign xlatScheme       = st.vm;
  assign dirtySummary     = st.dirty;
  assign modifyPrivilege  = st.modify_privilege;
  assign protectUserPages = st.protect_user_pages;
  assign execReadable     = st.exec_readable;

endmodule

`default_nettype wire

// File: machine_status_trap_stack_chk.sv
// port-level checker for the machine status block.
// assumes a bind onto machine_status_trap_stack, core clock domain only.
`timescale 1ns/1ps
`default_nettype none
`include "machine_status_map.svh"
module machine_status_trap_stack_chk #(
  parameter int XLEN = 64
) (
  input wire logic                         clk,
  input wire logic                         resetn,
  input wire machine_status_pkg::csr_req_t csrReq,
  input wire logic                         trapEnter,
  input wire machine_status_pkg::priv_t    trapTarget,
  input wire logic                         trapReturn,
  input wire logic [3:0]                   irqPending,
  input wire logic [1:0]                   extState,
  input wire logic [XLEN-1:0]              csrRdata,
  input wire logic                         csrValid,
  input wire logic                         csrFault,
  input wire machine_status_pkg::priv_t    curMode,
  input wire machine_status_pkg::priv_t    dataMode,
  input wire logic [3:0]                   irqTake,
  input wire logic [4:0]                   xlatScheme,
  input wire logic                         dirtySummary,
  input wire logic                         modifyPrivilege
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_answer; csrReq.op != machine_status_pkg::CSR_IDLE |=> csrValid; endproperty
  a_answer: assert property (p_answer) else $error("no csr answer");
  property p_unmapped;
    csrReq.op != machine_status_pkg::CSR_IDLE && !(csrReq.addr inside
      {`CSR_IMPL_VERSION, `CSR_HART_IDENTITY, `CSR_STATUS_WORD}) |=> csrFault && csrRdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_hart_ro;
    csrReq.op == machine_status_pkg::CSR_WRITE && csrReq.addr == `CSR_HART_IDENTITY |=> csrFault;
  endproperty
  a_hart_ro: assert property (p_hart_ro) else $error("identity write accepted");
  // irqTake lags the state by one cycle, so the masked enable shows two edges on
  property p_trap_mask; trapEnter && trapTarget == `PRIV_MACHINE |-> ##2 !irqTake[3]; endproperty
  a_trap_mask: assert property (p_trap_mask) else $error("enable not cleared on trap");
  property p_lower; curMode == `PRIV_MACHINE |=> irqTake[2:0] == 3'h0; endproperty
  a_lower: assert property (p_lower) else $error("lower interrupt taken");
  property p_higher; curMode == `PRIV_SUPER && irqPending[3] |=> irqTake[3]; endproperty
  a_higher: assert property (p_higher) else $error("higher interrupt masked");
  property p_legal;
    xlatScheme inside {`XLAT_BARE, `XLAT_BASE_BOUND, `XLAT_SPLIT_BOUND, `XLAT_PAGED_39, `XLAT_PAGED_48};
  endproperty
  a_legal: assert property (p_legal) else $error("illegal scheme held");
  property p_reset; $rose(resetn) |-> xlatScheme == `XLAT_BARE && curMode == `RESET_MODE; endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_dirty; extState == `EXT_DIRTY |=> dirtySummary; endproperty
  a_dirty: assert property (p_dirty) else $error("dirty summary missing");
  property p_data; !modifyPrivilege |=> dataMode == $past(curMode); endproperty
  a_data: assert property (p_data) else $error("data mode differs");
  c_trap: cover property (trapEnter);
  c_return: cover property (trapReturn);
  c_fault: cover property (csrFault);
endmodule
`default_nettype wire

// File: machine_status_trap_stack_test.sv
// self-checking bench for the machine status block.
// assumes default parameters: user and super modes, no hyp, no user irqs.
`timescale 1ns/1ps
`default_nettype none
`include "machine_status_map.svh"
module machine_status_trap_stack_test;
  localparam logic [11:0] ST = `CSR_STATUS_WORD;
  logic                         clk = 1'b0;
  logic                         resetn = 1'b0;
  machine_status_pkg::csr_req_t csrReq = '0;
  logic [63:0]                  csrWdata = '0;
  logic                         trapEnter = 1'b0;
  machine_status_pkg::priv_t    trapTarget = '0;
  logic                         trapReturn = 1'b0;
  machine_status_pkg::priv_t    returnFrom = '0;
  logic [3:0]                   irqPending = '0;
  logic [1:0]                   extState = '0;
  logic [63:0]                  csrRdata;
  logic                         csrValid;
  logic                         csrFault;
  machine_status_pkg::priv_t    curMode;
  machine_status_pkg::priv_t    dataMode;
  logic [3:0]                   irqTake;
  logic [4:0]                   xlatScheme;
  logic                         dirtySummary;
  logic                         modifyPrivilege;
  logic                         protectUserPages;
  logic                         execReadable;
  logic [4:0]                   held;
  logic [4:0]                   codes [11] = '{1, 2, 3, 8, 9, 11, 10, 12, 13, 31, 0};
  int                           failures = 0;
  int                           cmp_count = 0;

  machine_status_trap_stack u_dut (.*);

  always #10 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data is the word before the op, so a write also checks the old value
  task automatic csr(input machine_status_pkg::csr_op_t op, input logic [11:0] a, input logic [63:0] wd,
                     input logic [63:0] exp, input logic flt);
    @(negedge clk);
    csrReq = '{op, a};
    csrWdata = wd;
    @(negedge clk);
    csrReq = '0;
    chk(64'({csrValid, csrFault}), 64'({1'b1, flt}));
    chk(csrRdata, exp);
  endtask

  task automatic ev(input logic ret, input machine_status_pkg::priv_t m);
    @(negedge clk);
    trapEnter = !ret;
    trapReturn = ret;
    trapTarget = m;
    returnFrom = m;
    @(negedge clk);
    trapEnter = 1'b0;
    trapReturn = 1'b0;
  endtask

  task automatic final_report;
    $display("comparisons=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    csr(machine_status_pkg::CSR_SET, `CSR_IMPL_VERSION, '0, 64'h1200_0000_0000_0000, 1'b0);
    csr(machine_status_pkg::CSR_WRITE, `CSR_HART_IDENTITY, 64'hFFFF, '0, 1'b1);
    csr(machine_status_pkg::CSR_SET, `CSR_HART_IDENTITY, '0, '0, 1'b0);
    csr(machine_status_pkg::CSR_SET, 12'h7C0, '0, '0, 1'b1);
    csr(machine_status_pkg::CSR_WRITE, ST, 64'hF, '0, 1'b0);
    csr(machine_status_pkg::CSR_SET, ST, '0, 64'hA, 1'b0);
    held = `XLAT_BARE;
    foreach (codes[i]) begin
      csr(machine_status_pkg::CSR_WRITE, ST, {35'h0, codes[i], 24'hA}, {35'h0, held, 24'hA}, 1'b0);
      if (codes[i] inside {`XLAT_BASE_BOUND, `XLAT_SPLIT_BOUND, `XLAT_PAGED_39, `XLAT_PAGED_48, `XLAT_BARE})
        held = codes[i];
      chk(64'(xlatScheme), 64'(held));
    end
    irqPending = 4'hB;
    csr(machine_status_pkg::CSR_WRITE, ST, 64'h8, 64'hA, 1'b0);
    ev(1'b0, `PRIV_MACHINE);
    csr(machine_status_pkg::CSR_SET, ST, '0, 64'h1880, 1'b0);
    chk(64'({curMode, irqTake}), 64'h30);
    ev(1'b1, `PRIV_MACHINE);
    csr(machine_status_pkg::CSR_SET, ST, '0, 64'h88, 1'b0);
    chk(64'({curMode, irqTake}), 64'h38);
    ev(1'b0, `PRIV_SUPER);
    csr(machine_status_pkg::CSR_SET, ST, '0, 64'h1A8, 1'b0);
    chk(64'({curMode, irqTake}), 64'h18);
    ev(1'b1, `PRIV_SUPER);
    csr(machine_status_pkg::CSR_SET, ST, '0, 64'hAA, 1'b0);
    chk(64'({curMode, irqTake}), 64'h1A);
    csr(machine_status_pkg::CSR_SET, ST, 64'h0002_1800, 64'hAA, 1'b0);
    repeat (2) @(negedge clk);
    chk(64'({modifyPrivilege, dataMode, curMode}), 64'h1D);
    extState = `EXT_DIRTY;
    repeat (2) @(negedge clk);
    chk(64'(dirtySummary), 64'h1);
    csr(machine_status_pkg::CSR_SET, ST, 64'h000C_0000, 64'h8000_0000_0003_98AA, 1'b0);
    chk(64'({execReadable, protectUserPages}), 64'h3);
    // second reset mid-run must bring back machine mode and bare scheme
    extState = 2'h0;
    resetn = 1'b0;
    @(negedge clk);
    chk(64'({curMode, xlatScheme}), 64'h60);
    resetn = 1'b1;
    csr(machine_status_pkg::CSR_SET, ST, '0, '0, 1'b0);
    final_report();
  end
endmodule

bind machine_status_trap_stack machine_status_trap_stack_chk #(.XLEN(XLEN)) u_chk (.*);
`default_nettype wire
